// ---- hw/rsc_reset_source_controller.sv ----
/*
 Reset source controller: merges supply, pin, core and watchdog reset sources
 into one system reset, applies the power-up delay and records the cause.
 Assumes the supply monitor levels and the reset pin are asynchronous and the
 core/watchdog event strobes are one-cycle pulses on clk.
*/
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/10ps
module rsc_reset_source_controller
   import rsc_pkg::*;
#(
   parameter int unsigned POR_EXT_CYCLES = POR_EXT_CYC, // Power-on extension
   parameter int unsigned BOR_EXT_CYCLES = BOR_EXT_CYC, // Brown-out extension
   parameter int unsigned MS_CYCLES = MS_CYC // One millisecond of clk
)
(
   input wire logic clk, // System clock, 40 MHz
   input wire logic arst_n, // Asynchronous reset, active low
   input wire logic supply_above_por, // Supply above power-on threshold
   input wire logic supply_above_bor, // Supply above brown-out threshold
   input wire logic external_reset_pin_n, // External reset pin, active low
   input wire logic software_reset_exec, // Reset instruction executed
   input wire logic watchdog_timeout, // Watchdog time-out pulse
   input wire logic core_sleeping, // Core in sleep or idle
   input wire logic power_save_sleep, // Power-save sleep instruction
   input wire logic power_save_idle, // Power-save idle instruction
   input wire logic watchdog_clear_instruction, // Watchdog-clear instruction
   input wire logic hard_trap_valid, // Hard trap raised
   input wire logic [3:0] hard_trap_level, // Level of raised trap
   input wire logic [3:0] trap_in_service_level, // Level being serviced, 0 if none
   input wire logic [15:0] pin_select_cfg, // Pin-select control contents
   input wire logic [15:0] pin_select_shadow, // Hardware shadow copy
   input wire logic opcode_fetch_valid, // Instruction fetched for execution
   input wire logic [7:0] opcode_upper, // Upper instruction byte
   input wire logic pointer_use_valid, // Working register used as pointer
   input wire logic [3:0] pointer_reg_index, // Which working register
   input wire logic [15:0] wreg_written, // Write strobes per working register
   input wire logic flow_change_valid, // Program or vector flow change
   input wire logic flow_target_restricted, // Target in restricted protected area
   input wire logic [3:0] reg_addr, // Register address
   input wire logic [15:0] reg_wdata, // Register write data
   input wire logic reg_write, // Write strobe
   input wire logic reg_read, // Read strobe
   output logic [15:0] reg_rdata, // Read data, cycle after strobe
   output logic system_reset, // Common system reset, active high
   output logic clock_reload, // Reload clock source from configuration
   output logic [23:0] program_counter_init, // Program counter on reset release
   output logic watchdog_wake, // Wake core on watchdog in sleep
   output logic [15:0] wreg_init_mask // Working registers holding valid data
);
   logic rst_s1_reg, rst_n;
   logic [1:0] por_sync_reg, bor_sync_reg, pin_sync_reg;
   rsc_state_t state_reg;
   logic [22:0] cnt_reg;
   logic [2:0] power_up_delay_select;
   logic [15:0] cause_reg;
   logic [15:0] wreg_valid_reg;
   logic [7:0] pin_cnt_reg;
   logic pin_reset, warm_any, trap_conflict, cfg_mismatch, illegal_any, cold;
   logic [22:0] power_up_delay_timer_cycles;

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rst_s1_reg <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1_reg <= 1'b1;
         rst_n <= rst_s1_reg;
      end
   end

   // Asynchronous levels pass two flip-flops
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         por_sync_reg <= 2'b00;
         bor_sync_reg <= 2'b00;
         pin_sync_reg <= 2'b11;
      end
      else
      begin
         por_sync_reg <= {por_sync_reg[0], supply_above_por};
         bor_sync_reg <= {bor_sync_reg[0], supply_above_bor};
         pin_sync_reg <= {pin_sync_reg[0], external_reset_pin_n};
      end
   end

   // Glitch filter: pin must stay low for the minimum width
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pin_cnt_reg <= 8'h00;
      else if (pin_sync_reg[1])
         pin_cnt_reg <= 8'h00;
      else if (pin_cnt_reg != 8'(PIN_MIN_CYC))
         pin_cnt_reg <= pin_cnt_reg + 8'h01;
   end
   assign pin_reset = (pin_cnt_reg == 8'(PIN_MIN_CYC - 1)) && !pin_sync_reg[1];

   assign trap_conflict = hard_trap_valid && (hard_trap_level >= 4'(HARD_TRAP_LO))
      && (trap_in_service_level > hard_trap_level);
   assign cfg_mismatch = pin_select_cfg != pin_select_shadow;
   assign illegal_any = (opcode_fetch_valid && opcode_upper == ILLEGAL_OPCODE)
      || (pointer_use_valid && !wreg_valid_reg[pointer_reg_index])
      || (flow_change_valid && flow_target_restricted);
   // Watchdog is a reset only while the core is awake
   assign warm_any = pin_reset || software_reset_exec || (watchdog_timeout && !core_sleeping)
      || trap_conflict || cfg_mismatch || illegal_any;

   // 0,1,2,4,8,16,32 then 128 ms: eight settings, 0 to 128 ms
   always_comb
   begin
      if (power_up_delay_select == 3'h0)
         power_up_delay_timer_cycles = 23'h0;
      else
         power_up_delay_timer_cycles = 23'(MS_CYCLES << (power_up_delay_select == 3'h7 ? 7 : power_up_delay_select - 1));
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_POWER_ON;
         cnt_reg <= 23'h0;
      end
      else if (!por_sync_reg[1])
      begin
         state_reg <= ST_POWER_ON;
         cnt_reg <= 23'h0;
      end
      else if (!bor_sync_reg[1] && state_reg != ST_POWER_ON)
      begin
         state_reg <= ST_BROWN_OUT;
         cnt_reg <= 23'h0;
      end
      else
      begin
         unique case (state_reg)
            ST_POWER_ON:
               if (cnt_reg >= 23'(POR_EXT_CYCLES - 1))
               begin
                  state_reg <= ST_BROWN_OUT;
                  cnt_reg <= 23'h0;
               end
               else
                  cnt_reg <= cnt_reg + 23'h1;
            ST_BROWN_OUT:
               if (!bor_sync_reg[1])
                  cnt_reg <= 23'h0;
               else if (cnt_reg >= 23'(BOR_EXT_CYCLES - 1))
               begin
                  state_reg <= ST_POWER_UP_DELAY_TIMER;
                  cnt_reg <= 23'h0;
               end
               else
                  cnt_reg <= cnt_reg + 23'h1;
            ST_POWER_UP_DELAY_TIMER:
               if (cnt_reg >= power_up_delay_timer_cycles)
                  state_reg <= ST_RUN;
               else
                  cnt_reg <= cnt_reg + 23'h1;
            ST_RUN:
               cnt_reg <= 23'h0;
         endcase
      end
   end
   assign cold = state_reg != ST_RUN;

   // Outputs from flip-flops; warm reset lasts one cycle
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         system_reset <= 1'b1;
         clock_reload <= 1'b1;
         watchdog_wake <= 1'b0;
         program_counter_init <= RESET_VECTOR;
      end
      else
      begin
         system_reset <= cold || warm_any;
         clock_reload <= cold;
         watchdog_wake <= watchdog_timeout && core_sleeping;
         program_counter_init <= RESET_VECTOR;
      end
   end

   // Working registers start uninitialised, the stack pointer excepted
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         wreg_valid_reg <= 16'h0001 << STACK_PTR_INDEX;
      else if (cold || warm_any)
         wreg_valid_reg <= 16'h0001 << STACK_PTR_INDEX;
      else
         wreg_valid_reg <= wreg_valid_reg | wreg_written;
   end
   assign wreg_init_mask = wreg_valid_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         power_up_delay_select <= POWER_UP_DELAY_TIMER_SEL_RESET;
      else if (reg_write && reg_addr == ADDR_CTRL)
         power_up_delay_select <= reg_wdata[2:0];
   end

   // Hardware set wins over software write; power-on reloads the whole register, brown-out clears per flag
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         cause_reg <= CAUSE_RESET;
      else
      begin
         if (reg_write && reg_addr == ADDR_CAUSE)
            cause_reg <= reg_wdata & CAUSE_IMPL_MASK;
         if (power_save_sleep)
            cause_reg[FLAG_SLEEP] <= 1'b1;
         if (power_save_idle)
            cause_reg[FLAG_IDLE] <= 1'b1;
         if (power_save_sleep || power_save_idle || watchdog_clear_instruction)
            cause_reg[FLAG_WATCHDOG] <= 1'b0;
         if (state_reg == ST_POWER_ON)
         begin
            cause_reg <= 16'h0001 << FLAG_POWER_ON;
            cause_reg[FLAG_BROWN_OUT] <= 1'b1;
         end
         else if (state_reg == ST_BROWN_OUT)
         begin
            cause_reg[FLAG_TRAP] <= 1'b0;
            cause_reg[FLAG_ILLEGAL] <= 1'b0;
            cause_reg[FLAG_CFG_MISMATCH] <= 1'b0;
            cause_reg[FLAG_SOFTWARE] <= 1'b0;
            cause_reg[FLAG_WATCHDOG] <= 1'b0;
            cause_reg[FLAG_SLEEP] <= 1'b0;
            cause_reg[FLAG_IDLE] <= 1'b0;
            cause_reg[FLAG_BROWN_OUT] <= 1'b1;
         end
         else
         begin
            // Set in the cycle the reset asserts, kept through it
            if (pin_reset)
               cause_reg[FLAG_EXT_PIN] <= 1'b1;
            if (software_reset_exec)
               cause_reg[FLAG_SOFTWARE] <= 1'b1;
            if (watchdog_timeout)
               cause_reg[FLAG_WATCHDOG] <= 1'b1;
            if (trap_conflict)
               cause_reg[FLAG_TRAP] <= 1'b1;
            if (cfg_mismatch)
               cause_reg[FLAG_CFG_MISMATCH] <= 1'b1;
            if (illegal_any)
               cause_reg[FLAG_ILLEGAL] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata <= 16'h0000;
      else if (reg_read)
      begin
         unique case (reg_addr)
            ADDR_CAUSE: reg_rdata <= cause_reg;
            ADDR_CTRL: reg_rdata <= {13'h0000, power_up_delay_select};
            ADDR_STATUS: reg_rdata <= {14'h0000, state_reg};
            default: reg_rdata <= 16'h0000;
         endcase
      end
      else
         reg_rdata <= 16'h0000;
   end

   a_pin_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
      pin_reset && !cold |=> cause_reg[FLAG_EXT_PIN] && system_reset)
      else $error("pin reset not recorded");
   a_sw_one_cycle: assert property (@(posedge clk) disable iff (!rst_n)
      software_reset_exec && !cold |=> system_reset && cause_reg[FLAG_SOFTWARE])
      else $error("software reset not applied");
   a_wdt_sleep_wake: assert property (@(posedge clk) disable iff (!rst_n)
      watchdog_timeout && core_sleeping |=> watchdog_wake)
      else $error("watchdog wake missing");
   a_cold_holds_rst: assert property (@(posedge clk) disable iff (!rst_n)
      $past(cold) |-> system_reset && clock_reload)
      else $error("cold reset released early");
   a_trap_conflict: assert property (@(posedge clk) disable iff (!rst_n)
      trap_conflict && !cold |=> cause_reg[FLAG_TRAP])
      else $error("trap conflict not recorded");
   a_cfg_mismatch: assert property (@(posedge clk) disable iff (!rst_n)
      cfg_mismatch && !cold |=> cause_reg[FLAG_CFG_MISMATCH] && system_reset)
      else $error("mismatch not recorded");
   a_illegal_flag: assert property (@(posedge clk) disable iff (!rst_n)
      illegal_any && !cold |=> cause_reg[FLAG_ILLEGAL])
      else $error("illegal condition not recorded");
   a_bor_restart: assert property (@(posedge clk) disable iff (!rst_n)
      !bor_sync_reg[1] && state_reg != ST_POWER_ON && por_sync_reg[1] |=> state_reg == ST_BROWN_OUT)
      else $error("brown-out delay not restarted");
endmodule

// ---- hw/rsc_pkg.sv ----
/*
 Package for the reset source controller: register offsets, flag positions,
 reset values and timing constants. Assumes a 40 MHz system clock.
*/
package rsc_pkg;
   localparam int unsigned CLK_HZ = 40000000;
   // Register map (word offsets of the plain register port)
   localparam logic [3:0] ADDR_CAUSE = 4'h0;
   localparam logic [3:0] ADDR_CTRL = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   // Flag positions in the cause register
   localparam int FLAG_POWER_ON = 0;
   localparam int FLAG_BROWN_OUT = 1;
   localparam int FLAG_IDLE = 2;
   localparam int FLAG_SLEEP = 3;
   localparam int FLAG_WATCHDOG = 4;
   localparam int FLAG_SOFTWARE = 6;
   localparam int FLAG_EXT_PIN = 7;
   localparam int FLAG_CFG_MISMATCH = 9;
   localparam int FLAG_ILLEGAL = 14;
   localparam int FLAG_TRAP = 15;
   localparam logic [15:0] CAUSE_IMPL_MASK = 16'hC2DF;
   localparam logic [15:0] CAUSE_RESET = 16'h0000;
   localparam logic [2:0] POWER_UP_DELAY_TIMER_SEL_RESET = 3'h7;
   localparam logic [7:0] ILLEGAL_OPCODE = 8'h3F;
   localparam logic [23:0] RESET_VECTOR = 24'h000000;
   localparam int HARD_TRAP_LO = 13;
   localparam int HARD_TRAP_HI = 15;
   localparam int STACK_PTR_INDEX = 15;
   // Delays
   localparam int unsigned POR_EXT_NS = 30000;
   localparam int unsigned BOR_EXT_NS = 100000;
   localparam int unsigned PIN_MIN_NS = 2000;
   localparam int unsigned POR_EXT_CYC = POR_EXT_NS / 25;
   localparam int unsigned BOR_EXT_CYC = BOR_EXT_NS / 25;
   localparam int unsigned PIN_MIN_CYC = (PIN_MIN_NS + 24) / 25;
   localparam int unsigned MS_CYC = CLK_HZ / 1000;
   typedef enum logic [1:0] {
      ST_POWER_ON = 2'b00,
      ST_BROWN_OUT = 2'b01,
      ST_POWER_UP_DELAY_TIMER = 2'b10,
      ST_RUN = 2'b11
   } rsc_state_t;
endpackage

// ---- test/rsc_supervisor.sv ----
/*
 Model of an external supervisory circuit that drives the reset pin.
 Assumes a push-pull output, so the pin is high whenever no pulse is requested.
*/
`timescale 1ns/10ps
module rsc_supervisor
(
   input wire logic clk, // System clock
   output logic reset_pin_n // Drives the device reset pin, active low
);
   initial reset_pin_n = 1'b1;
   // Pulses shorter than the device filter must be ignored; longer ones must reset
   task automatic hold_low(input int n);
      @(posedge clk);
      reset_pin_n <= 1'b0;
      repeat (n) @(posedge clk);
      reset_pin_n <= 1'b1;
   endtask
endmodule

// ---- test/rsc_reset_source_controller_tb.sv ----
/*
 Self-checking bench for the reset source controller: register tasks, event
 pulses, pin pulses and supply dips. Assumes shortened delays: 4, 4, 2 cycles.
*/
`timescale 1ns/10ps
module rsc_reset_source_controller_tb
   import rsc_pkg::*;
;
   logic clk, arst_n, supply_above_por, supply_above_bor, external_reset_pin_n;
   logic software_reset_exec, watchdog_timeout, core_sleeping, power_save_sleep, power_save_idle;
   logic watchdog_clear_instruction, hard_trap_valid, opcode_fetch_valid, pointer_use_valid;
   logic flow_change_valid, flow_target_restricted, reg_write, reg_read, system_reset, clock_reload;
   logic watchdog_wake;
   logic [3:0] hard_trap_level, trap_in_service_level, pointer_reg_index, reg_addr;
   logic [15:0] pin_select_cfg, pin_select_shadow, wreg_written, reg_wdata, reg_rdata, wreg_init_mask;
   logic [7:0] opcode_upper;
   logic [23:0] program_counter_init;
   int n_fail = 0, n_compared = 0, cycles = 0, c0, c1, c3, c7;
   rsc_reset_source_controller #(.POR_EXT_CYCLES(4), .BOR_EXT_CYCLES(4), .MS_CYCLES(2)) u_dut (
      .clk(clk), .arst_n(arst_n), .supply_above_por(supply_above_por), .supply_above_bor(supply_above_bor),
      .external_reset_pin_n(external_reset_pin_n), .software_reset_exec(software_reset_exec),
      .watchdog_timeout(watchdog_timeout), .core_sleeping(core_sleeping), .power_save_sleep(power_save_sleep),
      .power_save_idle(power_save_idle), .watchdog_clear_instruction(watchdog_clear_instruction),
      .hard_trap_valid(hard_trap_valid), .hard_trap_level(hard_trap_level),
      .trap_in_service_level(trap_in_service_level), .pin_select_cfg(pin_select_cfg),
      .pin_select_shadow(pin_select_shadow), .opcode_fetch_valid(opcode_fetch_valid),
      .opcode_upper(opcode_upper), .pointer_use_valid(pointer_use_valid), .pointer_reg_index(pointer_reg_index),
      .wreg_written(wreg_written), .flow_change_valid(flow_change_valid),
      .flow_target_restricted(flow_target_restricted), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .system_reset(system_reset),
      .clock_reload(clock_reload), .program_counter_init(program_counter_init),
      .watchdog_wake(watchdog_wake), .wreg_init_mask(wreg_init_mask));
   rsc_supervisor u_sup (.clk(clk), .reset_pin_n(external_reset_pin_n));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         n_fail++;
         stop_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      @(posedge clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_read <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task automatic wait_run();
      int n;
      n = 0;
      while (system_reset !== 1'b0 && n < 3000)
      begin
         @(posedge clk);
         n++;
      end
   endtask
   task automatic set_ev(input int k, input logic v);
      case (k)
         0: software_reset_exec <= v;
         1: watchdog_timeout <= v;
         2: hard_trap_valid <= v;
         3: pin_select_cfg <= v ? 16'h1235 : 16'h1234;
         4: opcode_fetch_valid <= v;
         5: pointer_use_valid <= v;
         6: flow_change_valid <= v;
         7: power_save_sleep <= v;
         8: power_save_idle <= v;
         default: watchdog_clear_instruction <= v;
      endcase
   endtask
   // One-cycle event, then reset level, then cause contents, then flags cleared again
   task automatic ev(input int k, input logic exp_rst, input logic [15:0] exp_cause);
      @(posedge clk);
      set_ev(k, 1'b1);
      @(posedge clk);
      set_ev(k, 1'b0);
      #1 chk({system_reset, clock_reload}, {exp_rst, 1'b0});
      repeat (3) @(posedge clk);
      rd(ADDR_CAUSE, exp_cause);
      wr(ADDR_CAUSE, 16'h0000);
   endtask
   task automatic bor_cycle(input int dips, output int c);
      @(posedge clk);
      supply_above_bor <= 1'b0;
      repeat (10) @(posedge clk);
      #1 chk({system_reset, clock_reload}, 2'b11);
      @(posedge clk);
      for (int i = 0; i < dips; i++)
      begin
         supply_above_bor <= 1'b1;
         repeat (3) @(posedge clk);
         supply_above_bor <= 1'b0;
         repeat (10) @(posedge clk);
      end
      supply_above_bor <= 1'b1;
      c = 0;
      while (system_reset !== 1'b0 && c < 3000)
      begin
         @(posedge clk);
         c++;
      end
   endtask
   initial
   begin
      {arst_n, software_reset_exec, watchdog_timeout, core_sleeping, power_save_sleep} = '0;
      {power_save_idle, watchdog_clear_instruction, hard_trap_valid, opcode_fetch_valid} = '0;
      {pointer_use_valid, flow_change_valid, flow_target_restricted, reg_write, reg_read} = '0;
      {supply_above_por, supply_above_bor} = 2'b11;
      {hard_trap_level, trap_in_service_level, pointer_reg_index, reg_addr} = '0;
      {pin_select_cfg, pin_select_shadow, wreg_written, reg_wdata, opcode_upper} = {16'h1234, 16'h1234, 40'h0};
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      wait_run();
      #1 chk({clock_reload, program_counter_init}, {1'b0, RESET_VECTOR});
      rd(ADDR_CAUSE, 16'h0003);
      rd(ADDR_CTRL, {13'h0, POWER_UP_DELAY_TIMER_SEL_RESET});
      rd(ADDR_STATUS, 16'h0003);
      wr(ADDR_CAUSE, 16'hFFFF);
      @(posedge clk);
      #1 chk(system_reset, 1'b0);
      rd(ADDR_CAUSE, CAUSE_IMPL_MASK);
      wr(4'hF, 16'h0000);
      rd(4'hF, 16'h0000);
      wr(ADDR_CAUSE, 16'h0000);
      ev(0, 1'b1, 16'h0040);
      #1 chk(clock_reload, 1'b0);
      ev(1, 1'b1, 16'h0010);
      core_sleeping <= 1'b1;
      @(posedge clk);
      watchdog_timeout <= 1'b1;
      @(posedge clk);
      watchdog_timeout <= 1'b0;
      core_sleeping <= 1'b0;
      #1 chk({system_reset, watchdog_wake}, 2'b01);
      for (int k = 7; k < 10; k++)
      begin
         wr(ADDR_CAUSE, 16'h0010);
         ev(k, 1'b0, k == 7 ? 16'h0008 : k == 8 ? 16'h0004 : 16'h0000);
      end
      trap_in_service_level <= 4'hF;
      hard_trap_level <= 4'hD;
      ev(2, 1'b1, 16'h8000);
      trap_in_service_level <= 4'hD;
      hard_trap_level <= 4'hF;
      ev(2, 1'b0, 16'h0000);
      ev(3, 1'b1, 16'h0200);
      opcode_upper <= ILLEGAL_OPCODE;
      ev(4, 1'b1, 16'h4000);
      opcode_upper <= 8'h3E;
      ev(4, 1'b0, 16'h0000);
      pointer_reg_index <= 4'h3;
      #1 chk(wreg_init_mask, 16'h8000);
      ev(5, 1'b1, 16'h4000);
      wreg_written <= 16'h0008;
      @(posedge clk);
      wreg_written <= 16'h0000;
      @(posedge clk);
      #1 chk(wreg_init_mask, 16'h8008);
      ev(5, 1'b0, 16'h0000);
      flow_target_restricted <= 1'b1;
      ev(6, 1'b1, 16'h4000);
      flow_target_restricted <= 1'b0;
      ev(6, 1'b0, 16'h0000);
      u_sup.hold_low(20);
      repeat (100) @(posedge clk);
      #1 chk(system_reset, 1'b0);
      rd(ADDR_CAUSE, 16'h0000);
      u_sup.hold_low(120);
      wait_run();
      rd(ADDR_CAUSE, 16'h0080);
      wr(ADDR_CTRL, 16'h0000);
      wr(ADDR_CAUSE, 16'hC2D0);
      bor_cycle(0, c0);
      rd(ADDR_CAUSE, 16'h0082);
      bor_cycle(2, c1);
      chk(c1, c0);
      wr(ADDR_CTRL, 16'h0007);
      bor_cycle(0, c7);
      chk(c7 - c0, 256);
      wr(ADDR_CTRL, 16'h0003);
      bor_cycle(0, c3);
      chk(c3 - c0, 8);
      stop_test();
   end
endmodule
